// ==== logic/mie_params.svh ====
// Constants for the execution unit: offsets, reset values, timing.
// Included by bare name wherever needed.
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH

// Address of the program counter low byte
`define MIE_PCL_ADDR        7'h06
// System clocks per instruction cycle
`define MIE_CLKS_PER_CYCLE  3'h4
// Last phase index inside one instruction cycle
`define MIE_LAST_PHASE      2'h3
// Page of the last-page table read
`define MIE_LAST_PAGE       3'h7
// Base instruction cycle counts
`define MIE_BASE_ONE        2'h1
`define MIE_BASE_TWO        2'h2
// Reset values and byte constants
`define MIE_ACC_RST         8'h00
`define MIE_PC_RST          11'h000
`define MIE_TABLE_HIGH_LATCH_RST        6'h00
`define MIE_BYTE_ZERO       8'h00
`define MIE_BYTE_ONE        8'h01

`endif

// ==== logic/mie_pkg.sv ====
// Types shared by the execution unit, the memory model, the checker and the bench.
// Assumes mie_params.svh is on the include path.
package mie_pkg;

  typedef enum logic [5:0] {
    op_rotate_right_to_accumulator       = 6'h00,
    op_rotate_right_in_memory            = 6'h01,
    op_rotate_right_via_cy_to_accumulator = 6'h02,
    op_rotate_right_via_cy_in_memory     = 6'h03,
    op_rotate_left_to_accumulator        = 6'h04,
    op_rotate_left_in_memory             = 6'h05,
    op_rotate_left_via_carry_to_accumulator = 6'h06,
    op_rotate_left_via_carry_in_memory   = 6'h07,
    op_transfer_mem_to_acc               = 6'h08,
    op_transfer_acc_to_mem               = 6'h09,
    op_transfer_imm_to_acc               = 6'h0a,
    op_bit_clear                         = 6'h0b,
    op_bit_set                           = 6'h0c,
    op_goto_branch                       = 6'h0d,
    op_call                              = 6'h0e,
    op_leave_subroutine                  = 6'h0f,
    op_leave_subroutine_imm              = 6'h10,
    op_leave_interrupt_handler           = 6'h11,
    op_skip_if_zero                      = 6'h12,
    op_skip_zero_copy_to_accumulator     = 6'h13,
    op_skip_if_bit_clear                 = 6'h14,
    op_skip_if_bit_set                   = 6'h15,
    op_increment_skip_zero               = 6'h16,
    op_decrement_skip_zero               = 6'h17,
    op_increment_skip_zero_to_accumulator = 6'h18,
    op_decrement_skip_zero_to_accumulator = 6'h19,
    op_table_read_current_page           = 6'h1a,
    op_table_read_last_page              = 6'h1b,
    op_idle_instruction                  = 6'h1c,
    op_watchdog_clear                    = 6'h1d,
    op_watchdog_preclear_first           = 6'h1e,
    op_watchdog_preclear_second          = 6'h1f,
    op_nibble_exchange_in_memory         = 6'h20,
    op_nibble_exchange_to_accumulator    = 6'h21,
    op_halt                              = 6'h22
  } mie_op_t;

  typedef struct packed {
    mie_op_t     op;
    logic [6:0]  mem_addr;
    logic [2:0]  bit_idx;
    logic [7:0]  imm;
    logic [10:0] target;
  } mie_instr_t;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } mie_mem_wr_t;

  typedef struct packed {
    logic        timeout;
    logic        powerdown;
    logic        carry;
  } mie_flags_t;

endpackage

// ==== logic/mie_cycle_timer.sv ====
// Instruction cycle timer: four system clocks per instruction cycle.
// Assumes load is only honoured while idle; cycles is 1 to 3.
`include "mie_params.svh"

module mie_cycle_timer (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       load,
  input  wire logic [1:0] cycles,
  output logic            busy,
  output logic            tick,
  output logic            done
);

  logic [1:0] phase;
  logic [1:0] left;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy  <= 1'b0;
      phase <= 2'h0;
      left  <= 2'h0;
      tick  <= 1'b0;
      done  <= 1'b0;
    end else begin
      tick <= 1'b0;
      done <= 1'b0;
      if (load && !busy) begin
        busy  <= 1'b1;
        phase <= 2'h0;
        left  <= cycles;
      end else if (busy) begin
        // Each instruction cycle spans four system clocks [RQ17] [RQ18]
        if (phase == `MIE_LAST_PHASE) begin
          phase <= 2'h0;
          tick  <= 1'b1;
          left  <= left - 2'h1;
          if (left == 2'h1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          phase <= phase + 2'h1;
        end
      end
    end
  end

endmodule

// ==== logic/mie_exec.sv ====
// Execution unit for rotates, moves, bit ops, branches, skips, table reads,
// nibble swap, idle, watchdog clears and halt.
// Assumes the memory operand is valid with start and the program word by the
// end of the first instruction cycle of a table read.
//
// Overview of operation
// (RQ1) Rotate right plain: one cycle, flags kept
// (RQ2) Rotate right via carry: one cycle, carry only
// (RQ3) Rotate left plain: one cycle, flags kept
// (RQ4) Rotate left via carry: one cycle, carry only
// (RQ5) Transfers take one cycle, no flags
// (RQ6) Bit set/clear by 3-bit index, one cycle
// (RQ7) Jump and call: 11-bit target, two cycles
// (RQ8) Returns take two cycles, no flags
// (RQ9) Skip when operand zero, optional accumulator copy
// (RQ10) Bit test skips on zero or one
// (RQ11) Memory increment/decrement skip, both penalties
// (RQ12) Accumulator increment/decrement skip, skip penalty only
// (RQ13) Table read to memory and high latch
// (RQ14) Nibble swap in place or to accumulator
// (RQ15) Halt enters power-down, updates flags
// (RQ16) Pre-clear changes flags only when clearing
// (RQ17) Program counter low write adds one cycle
// (RQ18) Actual skip adds one cycle
// (RQ19) Immediate 8 bits, data address 7 bits
// (RQ20) Watchdog clear resets counter, clears flags
// (RQ21) Pre-clear needs the other pre-clear first
// (RQ22) Rotates wrap ends or pass through carry
`include "mie_params.svh"

module mie_exec (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               start,
  input  wire mie_pkg::mie_instr_t instr,
  input  wire logic [7:0]         mem_rdata,
  input  wire logic [7:0]         table_pointer,
  input  wire logic [13:0]        rom_data,
  input  wire logic [10:0]        ret_addr,
  input  wire logic               wdt_overflow,
  input  wire logic               wake,
  output mie_pkg::mie_mem_wr_t    mem_wr,
  output mie_pkg::mie_flags_t     flags,
  output logic [7:0]              acc,
  output logic [5:0]              table_high_latch,
  output logic [10:0]             pc,
  output logic [10:0]             rom_addr,
  output logic                    rom_re,
  output logic                    push_req,
  output logic [10:0]             push_addr,
  output logic                    pop_req,
  output logic                    leave_interrupt_handler_pulse,
  output logic                    skip_next,
  output logic                    wdt_clear,
  output logic                    halted,
  output logic                    busy,
  output logic                    done
);

  // Plain rotates wrap the outgoing bit to the other end [RQ22]
  function automatic logic [7:0] rot_r(input logic [7:0] v);
    rot_r = {v[0], v[7:1]};
  endfunction

  function automatic logic [7:0] rot_l(input logic [7:0] v);
    rot_l = {v[6:0], v[7]};
  endfunction

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    swap_nib = {v[3:0], v[7:4]};
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] i);
    bit_mask = `MIE_BYTE_ONE << i;
  endfunction

  function automatic logic is_tbl(input mie_pkg::mie_op_t o);
    is_tbl = (o == mie_pkg::op_table_read_current_page) ||
             (o == mie_pkg::op_table_read_last_page);
  endfunction

  logic       issue;
  logic       tick;
  logic       tbl_pending;
  logic       tbl_last;
  logic [6:0] tbl_dest;
  logic       pre1_seen;
  logic       pre2_seen;

  logic [7:0] next_result;
  logic       next_carry;
  logic       next_wr_mem;
  logic       next_wr_acc;
  logic       next_skip;
  logic       next_pcl;
  logic [1:0] next_base;
  logic [1:0] next_cycles;

  // A request while busy is ignored; the caller waits for done
  assign issue = start && !busy;

  always_comb begin
    next_result = mem_rdata;
    next_carry  = flags.carry;
    next_wr_mem = 1'b0;
    next_wr_acc = 1'b0;
    next_skip   = 1'b0;
    next_base   = `MIE_BASE_ONE;
    case (instr.op)
      mie_pkg::op_rotate_right_to_accumulator: begin
        next_result = rot_r(mem_rdata); // [RQ1]
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_rotate_right_in_memory: begin
        next_result = rot_r(mem_rdata); // [RQ1]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_rotate_right_via_cy_to_accumulator: begin
        next_result = {flags.carry, mem_rdata[7:1]}; // [RQ2] [RQ22]
        next_carry  = mem_rdata[0];
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_rotate_right_via_cy_in_memory: begin
        next_result = {flags.carry, mem_rdata[7:1]}; // [RQ2] [RQ22]
        next_carry  = mem_rdata[0];
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_rotate_left_to_accumulator: begin
        next_result = rot_l(mem_rdata); // [RQ3]
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_rotate_left_in_memory: begin
        next_result = rot_l(mem_rdata); // [RQ3]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_rotate_left_via_carry_to_accumulator: begin
        next_result = {mem_rdata[6:0], flags.carry}; // [RQ4] [RQ22]
        next_carry  = mem_rdata[7];
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_rotate_left_via_carry_in_memory: begin
        next_result = {mem_rdata[6:0], flags.carry}; // [RQ4] [RQ22]
        next_carry  = mem_rdata[7];
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_transfer_mem_to_acc: begin
        next_wr_acc = 1'b1; // [RQ5]
      end
      mie_pkg::op_transfer_acc_to_mem: begin
        next_result = acc; // [RQ5]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_transfer_imm_to_acc: begin
        next_result = instr.imm; // [RQ5] [RQ19]
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_bit_clear: begin
        next_result = mem_rdata & ~bit_mask(instr.bit_idx); // [RQ6]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_bit_set: begin
        next_result = mem_rdata | bit_mask(instr.bit_idx); // [RQ6]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_goto_branch,
      mie_pkg::op_call,
      mie_pkg::op_leave_subroutine,
      mie_pkg::op_leave_interrupt_handler: begin
        next_base = `MIE_BASE_TWO; // [RQ7] [RQ8]
      end
      mie_pkg::op_leave_subroutine_imm: begin
        next_base   = `MIE_BASE_TWO; // [RQ8]
        next_result = instr.imm;
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_skip_if_zero: begin
        next_skip = (mem_rdata == `MIE_BYTE_ZERO); // [RQ9]
      end
      mie_pkg::op_skip_zero_copy_to_accumulator: begin
        next_skip   = (mem_rdata == `MIE_BYTE_ZERO); // [RQ9]
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_skip_if_bit_clear: begin
        next_skip = !mem_rdata[instr.bit_idx]; // [RQ10]
      end
      mie_pkg::op_skip_if_bit_set: begin
        next_skip = mem_rdata[instr.bit_idx]; // [RQ10]
      end
      mie_pkg::op_increment_skip_zero: begin
        next_result = mem_rdata + `MIE_BYTE_ONE; // [RQ11]
        next_skip   = (next_result == `MIE_BYTE_ZERO);
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_decrement_skip_zero: begin
        next_result = mem_rdata - `MIE_BYTE_ONE; // [RQ11]
        next_skip   = (next_result == `MIE_BYTE_ZERO);
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_increment_skip_zero_to_accumulator: begin
        next_result = mem_rdata + `MIE_BYTE_ONE; // [RQ12]
        next_skip   = (next_result == `MIE_BYTE_ZERO);
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_decrement_skip_zero_to_accumulator: begin
        next_result = mem_rdata - `MIE_BYTE_ONE; // [RQ12]
        next_skip   = (next_result == `MIE_BYTE_ZERO);
        next_wr_acc = 1'b1;
      end
      mie_pkg::op_table_read_current_page,
      mie_pkg::op_table_read_last_page: begin
        next_base = `MIE_BASE_TWO; // [RQ13]
      end
      mie_pkg::op_nibble_exchange_in_memory: begin
        next_result = swap_nib(mem_rdata); // [RQ14]
        next_wr_mem = 1'b1;
      end
      mie_pkg::op_nibble_exchange_to_accumulator: begin
        next_result = swap_nib(mem_rdata); // [RQ14]
        next_wr_acc = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // Table reads write memory too, so a low-byte target costs a cycle
  assign next_pcl = (instr.mem_addr == `MIE_PCL_ADDR) && (next_wr_mem || is_tbl(instr.op));
  assign next_cycles = next_base + {1'b0, next_pcl} + {1'b0, next_skip}; // [RQ17] [RQ18]

  mie_cycle_timer u_timer (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .load   (issue),
    .cycles (next_cycles),
    .busy   (busy),
    .tick   (tick),
    .done   (done)
  );

  // Accumulator and carry; other flags are outside this block
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc         <= `MIE_ACC_RST;
      flags.carry <= 1'b0;
    end else if (issue) begin
      if (next_wr_acc) begin
        acc <= next_result; // [RQ1] [RQ3] [RQ5] [RQ9] [RQ12] [RQ14]
      end
      flags.carry <= next_carry; // [RQ2] [RQ4]
    end
  end

  // Data memory write port, one-cycle strobe
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mem_wr <= '0;
    end else if (issue) begin
      mem_wr.we   <= next_wr_mem; // [RQ1] [RQ3] [RQ6] [RQ11] [RQ14]
      mem_wr.addr <= instr.mem_addr; // [RQ19]
      mem_wr.data <= next_result;
    end else if (tick && tbl_pending) begin
      mem_wr.we   <= 1'b1; // [RQ13]
      mem_wr.addr <= tbl_dest;
      mem_wr.data <= rom_data[7:0];
    end else begin
      mem_wr.we <= 1'b0;
    end
  end

  // Table read: address out at issue, word taken after the first cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tbl_pending      <= 1'b0;
      tbl_last         <= 1'b0;
      tbl_dest         <= 7'h00;
      rom_addr         <= `MIE_PC_RST;
      rom_re           <= 1'b0;
      table_high_latch <= `MIE_TABLE_HIGH_LATCH_RST;
    end else if (issue) begin
      tbl_last    <= (instr.op == mie_pkg::op_table_read_last_page);
      tbl_dest    <= instr.mem_addr;
      tbl_pending <= is_tbl(instr.op);
      rom_re      <= is_tbl(instr.op);
      if (instr.op == mie_pkg::op_table_read_last_page) begin
        rom_addr <= {`MIE_LAST_PAGE, table_pointer}; // [RQ13]
      end else begin
        rom_addr <= {pc[10:8], table_pointer}; // [RQ13]
      end
    end else if (tick && tbl_pending) begin
      tbl_pending      <= 1'b0;
      rom_re           <= 1'b0;
      table_high_latch <= rom_data[13:8]; // [RQ13]
    end
  end

  // Program counter and stack requests
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pc         <= `MIE_PC_RST;
      push_req   <= 1'b0;
      push_addr  <= `MIE_PC_RST;
      pop_req    <= 1'b0;
      leave_interrupt_handler_pulse <= 1'b0;
      skip_next  <= 1'b0;
    end else begin
      push_req   <= 1'b0;
      pop_req    <= 1'b0;
      leave_interrupt_handler_pulse <= 1'b0;
      skip_next  <= 1'b0;
      if (issue) begin
        skip_next <= next_skip; // [RQ9] [RQ10] [RQ11] [RQ12]
        case (instr.op)
          mie_pkg::op_goto_branch: begin
            pc <= instr.target; // [RQ7]
          end
          mie_pkg::op_call: begin
            pc        <= instr.target; // [RQ7]
            push_req  <= 1'b1;
            push_addr <= pc + 11'h001;
          end
          mie_pkg::op_leave_subroutine,
          mie_pkg::op_leave_subroutine_imm,
          mie_pkg::op_leave_interrupt_handler: begin
            pc         <= ret_addr; // [RQ8]
            pop_req    <= 1'b1;
            leave_interrupt_handler_pulse <= (instr.op == mie_pkg::op_leave_interrupt_handler);
          end
          default: begin
            if (next_wr_mem && next_pcl) begin
              pc <= {pc[10:8], next_result}; // [RQ17]
            end else if (next_skip) begin
              pc <= pc + 11'h002; // [RQ18]
            end else begin
              pc <= pc + 11'h001;
            end
          end
        endcase
      end else if (tick && tbl_pending && tbl_dest == `MIE_PCL_ADDR) begin
        pc <= {pc[10:8], rom_data[7:0]}; // [RQ17]
      end
    end
  end

  // Watchdog clears, time-out and power-down flags
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flags.timeout   <= 1'b0;
      flags.powerdown <= 1'b0;
      pre1_seen       <= 1'b0;
      pre2_seen       <= 1'b0;
      wdt_clear       <= 1'b0;
      halted          <= 1'b0;
    end else begin
      wdt_clear <= 1'b0;
      if (wake) begin
        halted <= 1'b0;
      end
      if (issue) begin
        case (instr.op)
          mie_pkg::op_watchdog_clear: begin
            wdt_clear       <= 1'b1; // [RQ20]
            flags.timeout   <= 1'b0;
            flags.powerdown <= 1'b0;
            pre1_seen       <= 1'b0;
            pre2_seen       <= 1'b0;
          end
          mie_pkg::op_watchdog_preclear_first,
          mie_pkg::op_watchdog_preclear_second: begin
            if (instr.op == mie_pkg::op_watchdog_preclear_first ? pre2_seen : pre1_seen) begin
              wdt_clear       <= 1'b1; // [RQ21] [RQ16]
              flags.timeout   <= 1'b1;
              flags.powerdown <= 1'b0;
              pre1_seen       <= 1'b0;
              pre2_seen       <= 1'b0;
            end else if (instr.op == mie_pkg::op_watchdog_preclear_first) begin
              pre1_seen <= 1'b1; // [RQ21]
            end else begin
              pre2_seen <= 1'b1; // [RQ21]
            end
          end
          mie_pkg::op_halt: begin
            flags.timeout   <= 1'b0; // [RQ15]
            flags.powerdown <= 1'b1;
            halted          <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      // Overflow wins over a same-cycle clear so it is never lost
      if (wdt_overflow) begin
        flags.timeout <= 1'b1;
      end
    end
  end

endmodule

// ==== sim/mie_mem_model.sv ====
// Data and program memory beside the execution unit.
// Bench preloads data memory directly.
module mie_mem_model (
  input  wire logic                 mclk,
  input  wire logic [6:0]           rd_addr,
  input  wire mie_pkg::mie_mem_wr_t wr,
  input  wire logic [10:0]          rom_addr,
  input  wire logic                 rom_re,
  output logic [7:0]                rdata,
  output logic [13:0]               rom_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  dmem [0:127];
  logic [13:0] word;
  assign rdata = dmem[rd_addr];
  // Page bits land in the high part
  assign word = {rom_addr[10:5], rom_addr[7:0]} ^ 14'h155a;
  // Inverted while not read, to catch a late sample
  assign rom_data = rom_re ? word : ~word;
  initial begin
    for (int i = 0; i < 128; i++) dmem[i] = 8'h00;
  end
  always @(posedge mclk) begin
    if (wr.we) begin
      dmem[wr.addr] <= wr.data;
    end
  end
endmodule

// ==== sim/mie_exec_chk.sv ====
// Timing and result checks on the execution unit's ports.
// Bound into mie_exec; one clock, synchronous active-low reset.
`include "mie_params.svh"
module mie_exec_chk (
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire logic                 start,
  input wire mie_pkg::mie_instr_t  instr,
  input wire logic [7:0]           mem_rdata,
  input wire logic                 wdt_overflow,
  input wire mie_pkg::mie_mem_wr_t mem_wr,
  input wire mie_pkg::mie_flags_t  flags,
  input wire logic [7:0]           acc,
  input wire logic [10:0]          pc,
  input wire logic                 push_req,
  input wire logic [10:0]          push_addr,
  input wire logic                 skip_next,
  input wire logic                 wdt_clear,
  input wire logic                 halted,
  input wire logic                 busy,
  input wire logic                 done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic go;
  assign go = start && !busy;
  chk_imm_move:
    assert property (go && instr.op == mie_pkg::op_transfer_imm_to_acc |=> busy[*4]
      ##1 (done && acc == $past(instr.imm, 5))) else $error("imm move");
  chk_jump_len:
    assert property (go && instr.op == mie_pkg::op_goto_branch |=> busy[*8]
      ##1 (done && pc == $past(instr.target, 9))) else $error("jump length");
  chk_call_push:
    assert property (go && instr.op == mie_pkg::op_call |=> push_req
      && push_addr == $past(pc) + 11'h001 && pc == $past(instr.target)) else $error("call");
  chk_rot_carry:
    assert property (go && instr.op == mie_pkg::op_rotate_right_via_cy_to_accumulator
      |=> flags.carry == $past(mem_rdata[0])
      && acc == {$past(flags.carry), $past(mem_rdata[7:1])}) else $error("rotate carry");
  chk_skip_len:
    assert property ($rose(busy) && skip_next && !mem_wr.we |=> busy[*7] ##1 done)
      else $error("skip length");
  chk_pcl_len:
    assert property ($rose(busy) && mem_wr.we && mem_wr.addr == `MIE_PCL_ADDR && !skip_next
      |=> busy[*7] ##1 done) else $error("pcl length");
  chk_halt_flags:
    assert property (go && instr.op == mie_pkg::op_halt && !wdt_overflow
      |=> halted && flags.powerdown && !flags.timeout) else $error("halt flags");
  chk_wdt_clear:
    assert property (go && instr.op == mie_pkg::op_watchdog_clear && !wdt_overflow
      |=> wdt_clear && !flags.timeout && !flags.powerdown) else $error("watchdog clear");
endmodule
bind mie_exec mie_exec_chk u_chk (.mclk(mclk), .rst_b(rst_b), .start(start), .instr(instr),
  .mem_rdata(mem_rdata), .wdt_overflow(wdt_overflow), .mem_wr(mem_wr), .flags(flags),
  .acc(acc), .pc(pc), .push_req(push_req), .push_addr(push_addr), .skip_next(skip_next),
  .wdt_clear(wdt_clear), .halted(halted), .busy(busy), .done(done));

// ==== sim/mie_exec_tb.sv ====
// Bench for the execution unit: instruction results and timing.
// Assumes mie_mem_model stands in for data and program memory.
module mie_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 mclk, rst_b, start, wdt_overflow, wake, rom_re, busy, done, halted, c, nc;
  mie_pkg::mie_instr_t  instr;
  mie_pkg::mie_mem_wr_t mem_wr;
  mie_pkg::mie_flags_t  flags;
  logic [7:0]           mem_rdata, table_pointer, acc, d, r, im;
  logic [13:0]          rom_data, w;
  logic [10:0]          ret_addr, pc, rom_addr, p;
  logic [5:0]           tbl_hi;
  logic [2:0]           bi, pg;
  int                   fail_count = 0, check_count = 0, cycles = 0;
  mie_exec u_dut (.mclk(mclk), .rst_b(rst_b), .start(start), .instr(instr),
    .mem_rdata(mem_rdata), .table_pointer(table_pointer), .rom_data(rom_data),
    .ret_addr(ret_addr), .wdt_overflow(wdt_overflow), .wake(wake), .mem_wr(mem_wr),
    .flags(flags), .acc(acc), .table_high_latch(tbl_hi), .pc(pc), .rom_addr(rom_addr),
    .rom_re(rom_re), .push_req(), .push_addr(), .pop_req(), .leave_interrupt_handler_pulse(), .skip_next(),
    .wdt_clear(), .halted(halted), .busy(busy), .done(done));
  mie_mem_model u_mem (.mclk(mclk), .rd_addr(instr.mem_addr), .wr(mem_wr),
    .rom_addr(rom_addr), .rom_re(rom_re), .rdata(mem_rdata), .rom_data(rom_data));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // About 325 cycles are needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Issue one instruction; done follows 4*n edges after the take
  task automatic run(input mie_pkg::mie_op_t op, input logic [6:0] a, input int n);
    int k;
    instr = '{op: op, mem_addr: a, bit_idx: bi, imm: im, target: p};
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check("cycles", k, 4 * n);
  endtask
  // Skip forms: pc moves by n off the low pc byte
  task automatic sk(input mie_pkg::mie_op_t op, input logic [6:0] a, input logic [7:0] v,
                    input int n);
    logic [10:0] q;
    q = pc;
    u_mem.dmem[a] = v;
    run(op, a, n);
    if (a != 7'h06) check("skip pc", pc, q + 11'(n));
  endtask
  initial begin
    rst_b = 1'b0; start = 1'b0; instr = '0; wdt_overflow = 1'b0; wake = 1'b0;
    table_pointer = 8'h34; ret_addr = 11'h456; bi = 3'h0; im = 8'h00; p = 11'h000;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    c = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 8'h81 + 8'(i);
      u_mem.dmem[7'h10] = d;
      nc = c;
      case (i / 2)
        0: r = {d[0], d[7:1]};
        1: begin r = {c, d[7:1]}; nc = d[0]; end
        2: r = {d[6:0], d[7]};
        default: begin r = {d[6:0], c}; nc = d[7]; end
      endcase
      run(mie_pkg::mie_op_t'(i), 7'h10, 1);
      check("rotate", i[0] ? u_mem.dmem[7'h10] : acc, r);
      if (!i[0]) check("rotate mem kept", u_mem.dmem[7'h10], d);
      check("rotate flags", flags, {2'b00, nc});
      c = nc;
    end
    im = 8'ha5;
    run(mie_pkg::op_transfer_imm_to_acc, 7'h00, 1);
    run(mie_pkg::op_transfer_acc_to_mem, 7'h7f, 1);
    check("acc to mem", u_mem.dmem[7'h7f], 8'ha5);
    u_mem.dmem[7'h20] = 8'h3c;
    run(mie_pkg::op_transfer_mem_to_acc, 7'h20, 1);
    check("mem to acc", acc, 8'h3c);
    check("move flags", flags, {2'b00, c});
    for (int i = 0; i < 8; i++) begin
      bi = 3'(i);
      run(mie_pkg::op_bit_set, 7'h21, 1);
      check("bit set", u_mem.dmem[7'h21], 8'hff >> (7 - i));
    end
    run(mie_pkg::op_bit_clear, 7'h21, 1);
    check("bit clear", u_mem.dmem[7'h21], 8'h7f);
    run(mie_pkg::op_bit_set, 7'h06, 2);
    p = 11'h7ff;
    run(mie_pkg::op_goto_branch, 7'h00, 2);
    p = 11'h123;
    run(mie_pkg::op_call, 7'h00, 2);
    check("call pc", pc, 11'h123);
    im = 8'h77;
    for (int i = 15; i < 18; i++) begin
      run(mie_pkg::mie_op_t'(i), 7'h00, 2);
      check("return pc", pc, 11'h456);
    end
    check("return acc", acc, 8'h77);
    check("branch flags", flags, {2'b00, c});
    sk(mie_pkg::op_skip_if_zero, 7'h30, 8'h00, 2);
    sk(mie_pkg::op_skip_if_zero, 7'h30, 8'h01, 1);
    sk(mie_pkg::op_skip_zero_copy_to_accumulator, 7'h30, 8'h00, 2);
    check("copy acc", acc, 8'h00);
    bi = 3'h7;
    sk(mie_pkg::op_skip_if_bit_clear, 7'h30, 8'h7f, 2);
    sk(mie_pkg::op_skip_if_bit_clear, 7'h30, 8'h80, 1);
    sk(mie_pkg::op_skip_if_bit_set, 7'h30, 8'h80, 2);
    sk(mie_pkg::op_skip_if_bit_set, 7'h30, 8'h7f, 1);
    sk(mie_pkg::op_increment_skip_zero, 7'h30, 8'hff, 2);
    check("inc mem", u_mem.dmem[7'h30], 8'h00);
    sk(mie_pkg::op_decrement_skip_zero, 7'h30, 8'h02, 1);
    check("dec mem", u_mem.dmem[7'h30], 8'h01);
    sk(mie_pkg::op_decrement_skip_zero, 7'h06, 8'h01, 3);
    sk(mie_pkg::op_increment_skip_zero_to_accumulator, 7'h06, 8'hff, 2);
    check("acc form mem kept", u_mem.dmem[7'h06], 8'hff);
    sk(mie_pkg::op_decrement_skip_zero_to_accumulator, 7'h30, 8'h05, 1);
    check("dec acc", acc, 8'h04);
    check("skip flags", flags, {2'b00, c});
    for (int i = 0; i < 2; i++) begin
      pg = i ? 3'h7 : pc[10:8];
      w = {pg, 3'h1, 8'h34} ^ 14'h155a;
      run(mie_pkg::mie_op_t'(26 + i), 7'h31, 2);
      check("table low", u_mem.dmem[7'h31], w[7:0]);
      check("table high", tbl_hi, w[13:8]);
    end
    run(mie_pkg::op_table_read_last_page, 7'h06, 3);
    u_mem.dmem[7'h32] = 8'h3c;
    run(mie_pkg::op_nibble_exchange_to_accumulator, 7'h32, 1);
    check("swap acc", {acc, u_mem.dmem[7'h32]}, 16'hc33c);
    run(mie_pkg::op_nibble_exchange_in_memory, 7'h32, 1);
    check("swap mem", u_mem.dmem[7'h32], 8'hc3);
    wdt_overflow = 1'b1;
    @(posedge mclk);
    #1;
    wdt_overflow = 1'b0;
    run(mie_pkg::op_watchdog_preclear_first, 7'h00, 1);
    check("preclear alone", flags[2:1], 2'b10);
    run(mie_pkg::op_watchdog_clear, 7'h00, 1);
    check("clear", flags[2:1], 2'b00);
    run(mie_pkg::op_halt, 7'h00, 1);
    check("halt", {halted, flags[2:1]}, 3'b101);
    wake = 1'b1;
    @(posedge mclk);
    #1;
    wake = 1'b0;
    check("wake", halted, 1'b0);
    run(mie_pkg::op_watchdog_preclear_second, 7'h00, 1);
    check("second alone", flags[2:1], 2'b01);
    run(mie_pkg::op_watchdog_preclear_first, 7'h00, 1);
    check("both preclears", flags[2:1], 2'b10);
    p = pc;
    run(mie_pkg::op_idle_instruction, 7'h00, 1);
    check("idle pc", pc, p + 11'h001);
    tally_and_finish();
  end
endmodule
